// [core/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] OFS_RESULT_LOW = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CONTROL_A = 8'h08;
  localparam logic [7:0] OFS_CONTROL_B = 8'h0C;
  localparam logic [7:0] OFS_TEMP_SENSOR = 8'h10;
  localparam logic [7:0] OFS_BANDGAP = 8'h14;
  localparam logic [7:0] OFS_HOT_CAL_HIGH = 8'h18;
  localparam logic [7:0] OFS_HOT_CAL_LOW = 8'h1C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRLA_START_BIT = 7;
  localparam int CTRLA_BUSY_BIT = 6;
  localparam int CTRLA_ENABLE_BIT = 5;
  localparam int CTRLA_JUSTIFY_BIT = 4;
  localparam int CTRLA_CHAN_MSB = 3;
  localparam int CTRLA_CHAN_LSB = 0;
  localparam int CTRLB_SRC_MSB = 7;
  localparam int CTRLB_SRC_LSB = 5;
  localparam int CTRLB_REF_MSB = 4;
  localparam int CTRLB_REF_LSB = 3;
  localparam int CTRLB_DIV_MSB = 2;
  localparam int CTRLB_DIV_LSB = 0;
  localparam int INT_DONE_BIT = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [1:0] TEMP_SENSOR_RESET = 2'h2;
  localparam logic BANDGAP_RESET = 1'b0;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [2:0] SRC_EXTERNAL = 3'h0;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_TEMP_SENSOR = 3'h2;
  localparam logic [2:0] SRC_AMP_OUTPUT = 3'h3;
  localparam logic [2:0] SRC_AMP_POS_INPUT = 3'h4;
  localparam logic [2:0] SRC_EXTERNAL_ALT1 = 3'h5;
  localparam logic [2:0] SRC_EXTERNAL_ALT2 = 3'h6;
  localparam logic [2:0] SRC_FORBIDDEN = 3'h7;
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_TEMP_SENSOR = 2'h2;
  localparam int CHANNEL_COUNT = 8;

  // ==========================================================================
  // AXI response codes
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : adc_ctrl_pkg

// [core/adc_clock_divider.sv]
`timescale 1ns/100ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [2:0] divide_code,
  // Conversion clock tick
  output logic tick
);

  logic [6:0] count_r;
  logic [6:0] count_nxt;
  logic [6:0] terminal;
  logic wrap;

  // One tick every two-to-the-code system clocks; code 0 ticks every cycle.
  assign terminal = 7'(({7'h00, 1'b1} << divide_code) - 8'h01);
  assign wrap = (count_r >= terminal);
  assign count_nxt = (!enable || wrap) ? 7'h00 : 7'(count_r + 7'h01);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      tick <= enable && wrap;
    end
  end

endmodule : adc_clock_divider

// [core/adc_control_registers.sv]
`timescale 1ns/100ps
module adc_control_registers
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog conversion core
  output logic converter_enable,
  output logic conv_start,
  output logic conv_clk_tick,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // Input and reference routing
  output logic [7:0] analog_inputs,
  output logic sel_bandgap_voltage,
  output logic sel_temp_sensor_output,
  output logic sel_amplifier_output,
  output logic sel_amplifier_positive_input,
  output logic ref_external,
  output logic ref_supply,
  output logic ref_temp_sensor,
  // Analog block enables and factory value
  output logic temp_sensor_enable,
  output logic bandgap_enable,
  input wire logic [11:0] hot_cal_value,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Result formatting
  // ==========================================================================
  // Unused bits of the selected layout are forced to zero.
  function automatic logic [7:0] format_result(
    input logic [11:0] data,
    input logic justify,
    input logic high_byte
  );
    logic [15:0] packed_word;
    packed_word = justify ? {4'h0, data} : {data, 4'h0};
    return high_byte ? packed_word[15:8] : packed_word[7:0];
  endfunction : format_result
  function automatic logic reg_mapped(input logic [7:0] addr);
    return (addr == OFS_RESULT_LOW) || (addr == OFS_RESULT_HIGH) ||
           (addr == OFS_CONTROL_A) || (addr == OFS_CONTROL_B) ||
           (addr == OFS_TEMP_SENSOR) || (addr == OFS_BANDGAP) ||
           (addr == OFS_HOT_CAL_HIGH) || (addr == OFS_HOT_CAL_LOW) ||
           (addr == OFS_INT_STATUS) || (addr == OFS_INT_MASK);
  endfunction : reg_mapped

  // ==========================================================================
  // State
  // ==========================================================================
  logic aw_hold_r;
  logic [7:0] aw_addr_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic start_r;
  logic enable_r;
  logic justify_r;
  logic [3:0] chan_r;
  logic busy_r;
  logic busy_nxt;
  logic [2:0] src_r;
  logic [1:0] ref_r;
  logic [2:0] div_r;
  logic [1:0] temp_ctrl_r;
  logic bandgap_r;
  logic [11:0] result_r;
  logic status_r;
  logic status_nxt;
  logic mask_r;
  logic start_pulse_r;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_fire = (aw_hold_r || aw_take) && (w_hold_r || w_take) && !bvalid_r;
  wire [7:0] wr_addr = aw_hold_r ? aw_addr_r : awaddr;
  wire [31:0] wr_data = w_hold_r ? w_data_r : wdata;
  wire [3:0] wr_strb = w_hold_r ? w_strb_r : wstrb;
  wire wr_lane = wr_fire && wr_strb[0];
  wire wsel_ctrl_a = (wr_addr == OFS_CONTROL_A);
  wire wsel_ctrl_b = (wr_addr == OFS_CONTROL_B);
  wire wsel_temp = (wr_addr == OFS_TEMP_SENSOR);
  wire wsel_bandgap = (wr_addr == OFS_BANDGAP);
  wire wsel_status = (wr_addr == OFS_INT_STATUS);
  wire wsel_mask = (wr_addr == OFS_INT_MASK);
  wire wr_hit = reg_mapped(wr_addr);
  wire wr_ctrl_a = wr_lane && wsel_ctrl_a;
  wire wr_ctrl_b = wr_lane && wsel_ctrl_b;
  wire new_start = wr_data[CTRLA_START_BIT];
  wire new_enable = wr_data[CTRLA_ENABLE_BIT];
  wire [2:0] new_src = wr_data[CTRLB_SRC_MSB:CTRLB_SRC_LSB];
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready = !w_hold_r && !bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= (aw_hold_r || aw_take) && !wr_fire;
      w_hold_r <= (w_hold_r || w_take) && !wr_fire;
      if (aw_take)
        aw_addr_r <= awaddr;
      if (w_take)
      begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  wire ar_take = arvalid && arready;
  wire [7:0] ctrl_a_view = {start_r, busy_r, enable_r, justify_r, chan_r};
  wire [7:0] ctrl_b_view = {src_r, ref_r, div_r};
  wire rsel_hit = reg_mapped(araddr);
  wire [7:0] rd_byte =
    (araddr == OFS_RESULT_LOW) ? format_result(result_r, justify_r, 1'b0) :
    (araddr == OFS_RESULT_HIGH) ? format_result(result_r, justify_r, 1'b1) :
    (araddr == OFS_CONTROL_A) ? ctrl_a_view :
    (araddr == OFS_CONTROL_B) ? ctrl_b_view :
    (araddr == OFS_TEMP_SENSOR) ? {6'h00, temp_ctrl_r} :
    (araddr == OFS_BANDGAP) ? {7'h00, bandgap_r} :
    (araddr == OFS_HOT_CAL_HIGH) ? format_result(hot_cal_value, 1'b0, 1'b1) :
    (araddr == OFS_HOT_CAL_LOW) ? format_result(hot_cal_value, 1'b0, 1'b0) :
    (araddr == OFS_INT_STATUS) ? {7'h00, status_r} :
    (araddr == OFS_INT_MASK) ? {7'h00, mask_r} :
    8'h00;

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= rsel_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  // ==========================================================================
  // Conversion control
  // ==========================================================================
  // A start is the write that takes a stored one back to zero with the
  // converter enabled; a start while busy is ignored.
  wire initiate = wr_ctrl_a && start_r && !new_start && new_enable && !busy_r;
  wire done_evt = conv_done && busy_r && enable_r;
  // Clearing the enable aborts a conversion in progress.
  assign busy_nxt = enable_r && (initiate || (busy_r && !done_evt));

  // Results change only on a completion taken while enabled, in the same
  // edge at which busy falls.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      start_r <= CONTROL_A_RESET[CTRLA_START_BIT];
      enable_r <= CONTROL_A_RESET[CTRLA_ENABLE_BIT];
      justify_r <= CONTROL_A_RESET[CTRLA_JUSTIFY_BIT];
      chan_r <= CONTROL_A_RESET[CTRLA_CHAN_MSB:CTRLA_CHAN_LSB];
      busy_r <= CONTROL_A_RESET[CTRLA_BUSY_BIT];
      start_pulse_r <= 1'b0;
      result_r <= RESULT_RESET;
    end
    else
    begin
      if (wr_ctrl_a)
      begin
        start_r <= new_start;
        enable_r <= new_enable;
        justify_r <= wr_data[CTRLA_JUSTIFY_BIT];
        chan_r <= wr_data[CTRLA_CHAN_MSB:CTRLA_CHAN_LSB];
      end
      busy_r <= busy_nxt;
      start_pulse_r <= initiate;
      if (done_evt)
        result_r <= conv_data;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      src_r <= CONTROL_B_RESET[CTRLB_SRC_MSB:CTRLB_SRC_LSB];
      ref_r <= CONTROL_B_RESET[CTRLB_REF_MSB:CTRLB_REF_LSB];
      div_r <= CONTROL_B_RESET[CTRLB_DIV_MSB:CTRLB_DIV_LSB];
      temp_ctrl_r <= TEMP_SENSOR_RESET;
      bandgap_r <= BANDGAP_RESET;
      mask_r <= 1'b0;
      status_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl_b)
      begin
        if (new_src != SRC_FORBIDDEN)
          src_r <= new_src;
        ref_r <= wr_data[CTRLB_REF_MSB:CTRLB_REF_LSB];
        div_r <= wr_data[CTRLB_DIV_MSB:CTRLB_DIV_LSB];
      end
      if (wr_lane && wsel_temp)
        temp_ctrl_r <= wr_data[1:0];
      if (wr_lane && wsel_bandgap)
        bandgap_r <= wr_data[0];
      if (wr_lane && wsel_mask)
        mask_r <= wr_data[INT_DONE_BIT];
      status_r <= status_nxt;
    end
  end

  // ==========================================================================
  // Interrupt
  // ==========================================================================
  // A completion in the clearing cycle keeps the flag set.
  wire status_clear = wr_lane && wsel_status && wr_data[INT_DONE_BIT];
  assign status_nxt = done_evt || (status_r && !status_clear);

  assign irq = status_r && mask_r;

  // ==========================================================================
  // Routing decode
  // ==========================================================================
  wire src_is_external = (src_r == SRC_EXTERNAL) || (src_r == SRC_EXTERNAL_ALT1) ||
                         (src_r == SRC_EXTERNAL_ALT2);
  wire chan_valid = !chan_r[3];
  assign analog_inputs = (src_is_external && chan_valid) ?
                         8'(9'h001 << chan_r[2:0]) : 8'h00;
  assign sel_bandgap_voltage = (src_r == SRC_BANDGAP);
  assign sel_temp_sensor_output = (src_r == SRC_TEMP_SENSOR);
  assign sel_amplifier_output = (src_r == SRC_AMP_OUTPUT);
  assign sel_amplifier_positive_input = (src_r == SRC_AMP_POS_INPUT);
  assign ref_external = (ref_r == REF_EXTERNAL);
  assign ref_temp_sensor = (ref_r == REF_TEMP_SENSOR);
  assign ref_supply = ref_r[0];
  assign converter_enable = enable_r;
  assign conv_start = start_pulse_r;
  assign temp_sensor_enable = temp_ctrl_r[0];
  assign bandgap_enable = bandgap_r;

  // ==========================================================================
  // Conversion clock
  // ==========================================================================
  adc_clock_divider u_clock_divider (
    .mclk(mclk),
    .rst(rst),
    .enable(enable_r),
    .divide_code(div_r),
    .tick(conv_clk_tick)
  );

endmodule : adc_control_registers

// [bench/adc_control_registers_properties.sv]
`timescale 1ns/100ps
module adc_control_registers_properties
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus responses
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  // Converter and routing
  input wire logic converter_enable,
  input wire logic conv_start,
  input wire logic conv_clk_tick,
  input wire logic conv_done,
  input wire logic [7:0] analog_inputs,
  input wire logic sel_bandgap_voltage,
  input wire logic sel_temp_sensor_output,
  input wire logic sel_amplifier_output,
  input wire logic sel_amplifier_positive_input,
  input wire logic ref_external,
  input wire logic ref_supply,
  input wire logic ref_temp_sensor,
  // Interrupt
  input wire logic irq
);
  // ==========
  // Sequences
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire internal_source = sel_bandgap_voltage | sel_temp_sensor_output | sel_amplifier_output |
    sel_amplifier_positive_input;
  sequence s_resp_wait;
    bvalid && !bready;
  endsequence
  sequence s_write_done;
    $rose(bvalid);
  endsequence
  sequence s_start_quiet;
    !conv_start [*3];
  endsequence
  // ==========
  // Properties
  AST_RESP_HOLD: assert property (s_resp_wait |=> bvalid)
    else $error("write response dropped early");
  AST_START_CAUSE: assert property (conv_start |-> converter_enable ##0 s_write_done)
    else $error("start pulse without enabled write");
  AST_START_ONCE: assert property (conv_start |=> s_start_quiet)
    else $error("start pulse repeated");
  AST_TICK_OFF: assert property (!converter_enable [*2] |-> !conv_clk_tick)
    else $error("clock tick while disabled");
  AST_CHAN_ONEHOT: assert property ($onehot0(analog_inputs))
    else $error("more than one channel routed");
  AST_INTERNAL_NO_CHAN: assert property (internal_source |-> analog_inputs == 8'h00)
    else $error("channel routed with internal source");
  AST_SRC_ONEHOT: assert property ($onehot0({sel_bandgap_voltage, sel_temp_sensor_output,
    sel_amplifier_output, sel_amplifier_positive_input}))
    else $error("several internal sources");
  AST_REF_ONEHOT: assert property ($onehot({ref_external, ref_supply, ref_temp_sensor}))
    else $error("reference not one hot");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(conv_done) || $rose(bvalid))
    else $error("interrupt without cause");
  AST_RDATA_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule : adc_control_registers_properties

bind adc_control_registers adc_control_registers_properties
  adc_control_registers_properties_inst
(
  .mclk, .rst, .bvalid, .bready, .rdata, .rvalid, .converter_enable, .conv_start,
  .conv_clk_tick, .conv_done, .analog_inputs, .sel_bandgap_voltage, .sel_temp_sensor_output,
  .sel_amplifier_output, .sel_amplifier_positive_input, .ref_external, .ref_supply,
  .ref_temp_sensor, .irq
);

// [bench/adc_control_registers_tb_top.sv]
`timescale 1ns/100ps
module adc_control_registers_tb_top
  import adc_ctrl_pkg::*;
;
  // ==========
  // Signals
  logic mclk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic conv_done = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic [11:0] conv_data = 12'h000, hot_cal_value = 12'hA5C;
  logic awready, wready, bvalid, arready, rvalid, converter_enable, conv_start, conv_clk_tick;
  logic sel_bandgap_voltage, sel_temp_sensor_output, sel_amplifier_output;
  logic sel_amplifier_positive_input, ref_external, ref_supply, ref_temp_sensor;
  logic temp_sensor_enable, bandgap_enable, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0] analog_inputs;
  int fail_count = 0, n_compared = 0, n_starts = 0;

  adc_control_registers adc_control_registers_inst
  (
    .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .converter_enable, .conv_start, .conv_clk_tick, .conv_done, .conv_data, .analog_inputs,
    .sel_bandgap_voltage, .sel_temp_sensor_output, .sel_amplifier_output,
    .sel_amplifier_positive_input, .ref_external, .ref_supply, .ref_temp_sensor,
    .temp_sensor_enable, .bandgap_enable, .hot_cal_value, .irq
  );

  always #2 mclk = ~mclk;
  // Start pulses are counted mid-cycle, where they are settled.
  always @(negedge mclk)
    if (conv_start === 1'b1) n_starts++;

  // ==========
  // Shared tasks
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tmo();
    chk("handshake timeout", 32'h0, 32'h1);
    give_verdict();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (!(bvalid && bready)) tmo();
    rs = bresp;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (rvalid !== 1'b1) tmo();
    rd = rdata;
    rs = rresp;
  endtask : rd_reg

  task automatic tick_wait(output int n);
    for (n = 1; n < 300; n++)
    begin
      @(posedge mclk);
      if (conv_clk_tick === 1'b1) break;
    end
    if (n == 300) tmo();
  endtask : tick_wait

  task automatic pulse(input logic [11:0] d);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    conv_data <= ~d;
  endtask : pulse

  function automatic logic [7:0] fmt(input logic [11:0] d, input logic j, input logic hi);
    if (j)
      return hi ? {4'h0, d[11:8]} : d[7:0];
    return hi ? d[11:4] : {d[3:0], 4'h0};
  endfunction : fmt

  task automatic convert(input logic [7:0] ctl, input logic [11:0] d);
    int s;
    s = n_starts;
    wr(OFS_CONTROL_A, ctl | 8'h80);
    wr(OFS_CONTROL_A, ctl);
    chk("start count", 32'(n_starts - s), 32'(ctl[5]));
    chk("converter enable", converter_enable, ctl[5]);
    rd_reg(OFS_CONTROL_A);
    chk("busy set", rd, {24'h0, ctl | {1'b0, ctl[5], 6'h00}});
    pulse(d);
  endtask : convert

  // ==========
  // Scenarios
  task automatic sc_reset();
    logic [7:0] adr [10];
    logic [7:0] exp [10];
    adr = '{OFS_RESULT_LOW, OFS_RESULT_HIGH, OFS_CONTROL_A, OFS_CONTROL_B, OFS_TEMP_SENSOR,
      OFS_BANDGAP, OFS_HOT_CAL_HIGH, OFS_HOT_CAL_LOW, OFS_INT_STATUS, OFS_INT_MASK};
    exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'hA5, 8'hC0, 8'h00, 8'h00};
    foreach (adr[i])
    begin
      rd_reg(adr[i]);
      chk("reset value", rd, {24'h0, exp[i]});
    end
    chk("reset channel", analog_inputs, 8'h01);
    chk("reset reference", {ref_temp_sensor, ref_supply, ref_external}, 3'b001);
  endtask : sc_reset

  task automatic sc_bus();
    rd_reg(8'h28);
    chk("unmapped rresp", rs, RESP_SLVERR);
    chk("unmapped rdata", rd, 32'h0);
    wr(8'h28, 8'hFF);
    chk("unmapped bresp", rs, RESP_SLVERR);
    wr(OFS_CONTROL_A, 8'h40);
    wr(OFS_RESULT_LOW, 8'hFF);
    chk("read-only bresp", rs, RESP_OKAY);
    rd_reg(OFS_CONTROL_A);
    chk("busy write", rd, 32'h0);
    chk("mapped rresp", rs, RESP_OKAY);
    rd_reg(OFS_RESULT_LOW);
    chk("result write", rd, 32'h0);
    wr(OFS_TEMP_SENSOR, 8'h03);
    wr(OFS_BANDGAP, 8'h01);
    chk("analog enables", {temp_sensor_enable, bandgap_enable}, 2'b11);
  endtask : sc_bus

  task automatic sc_routing();
    logic [3:0] src_exp;
    logic [2:0] ref_exp;
    for (int c = 0; c < 16; c++)
    begin
      wr(OFS_CONTROL_A, 8'(c));
      chk("channel", analog_inputs, c < 8 ? 8'h01 << c : 8'h00);
    end
    for (int s = 0; s < 7; s++)
    begin
      src_exp = (s > 0 && s < 5) ? 4'h1 << (s - 1) : 4'h0;
      ref_exp = (s % 4 == 0) ? 3'b001 : (s % 4 == 2) ? 3'b100 : 3'b010;
      // An internal source goes in only while no external channel is selected.
      if (src_exp != 4'h0) wr(OFS_CONTROL_A, 8'h0B);
      wr(OFS_CONTROL_B, 8'(s * 32 + (s % 4) * 8));
      if (src_exp == 4'h0) wr(OFS_CONTROL_A, 8'h03);
      chk("source", {sel_amplifier_positive_input, sel_amplifier_output,
        sel_temp_sensor_output, sel_bandgap_voltage}, src_exp);
      chk("source channel", analog_inputs, src_exp != 0 ? 8'h00 : 8'h08);
      chk("reference", {ref_temp_sensor, ref_supply, ref_external}, ref_exp);
    end
    wr(OFS_CONTROL_B, 8'hE0);
    rd_reg(OFS_CONTROL_B);
    chk("forbidden source", rd, 32'hC0);
  endtask : sc_routing

  task automatic sc_divider();
    int n;
    wr(OFS_CONTROL_A, 8'h20);
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_CONTROL_B, 8'(k));
      tick_wait(n);
      tick_wait(n);
      chk("tick period", 32'(n), 32'(1 << k));
    end
  endtask : sc_divider

  task automatic sc_convert();
    logic [11:0] d;
    for (int j = 0; j < 2; j++)
    begin
      d = j ? 12'h3C5 : 12'h9B6;
      wr(OFS_INT_MASK, 8'(j));
      convert(8'(8'h20 + j * 16), d);
      rd_reg(OFS_CONTROL_A);
      chk("busy clear", rd[6], 1'b0);
      rd_reg(OFS_RESULT_HIGH);
      chk("result high", rd, fmt(d, j[0], 1'b1));
      rd_reg(OFS_RESULT_LOW);
      chk("result low", rd, fmt(d, j[0], 1'b0));
      rd_reg(OFS_INT_STATUS);
      chk("done status", rd, 32'h1);
      chk("irq level", irq, j[0]);
      wr(OFS_INT_STATUS, 8'h01);
    end
    chk("irq cleared", irq, 1'b0);
  endtask : sc_convert

  task automatic sc_disable();
    convert(8'h10, 12'h111);
    rd_reg(OFS_RESULT_HIGH);
    chk("held high", rd, 32'h03);
    wr(OFS_CONTROL_A, 8'hB0);
    wr(OFS_CONTROL_A, 8'h30);
    wr(OFS_CONTROL_A, 8'h10);
    pulse(12'h222);
    rd_reg(OFS_CONTROL_A);
    chk("abort busy", rd, 32'h10);
    rd_reg(OFS_RESULT_LOW);
    chk("held low", rd, 32'hC5);
    rd_reg(OFS_INT_STATUS);
    chk("abort status", rd, 32'h0);
  endtask : sc_disable

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sc_reset();
    sc_bus();
    sc_routing();
    sc_divider();
    sc_convert();
    sc_disable();
    give_verdict();
  end
endmodule : adc_control_registers_tb_top
